// File: pkg/card_pkg.sv
package card_pkg;

    // register byte addresses on the bus
    localparam logic [4:0] ADDR_MODE   = 5'h00;
    localparam logic [4:0] ADDR_CTRL   = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_TXDATA = 5'h0C;
    localparam logic [4:0] ADDR_RXDATA = 5'h10;
    localparam logic [4:0] ADDR_CARD   = 5'h14;
    localparam logic [4:0] ADDR_ETU    = 5'h18;
    localparam logic [4:0] ADDR_CLKDIV = 5'h1C;

    // serial_mode_reg fields
    localparam int MODE_TIMING_SEL = 0;
    localparam int MODE_PAR_ODD    = 1;

    // serial_control_reg fields
    localparam int CTRL_CLK_EN_LOW  = 0;
    localparam int CTRL_CLK_EN_HIGH = 1;
    localparam int CTRL_TRANSMIT_END_FLAG_IE     = 2;
    localparam int CTRL_RX_EN       = 4;
    localparam int CTRL_TX_EN       = 5;
    localparam int CTRL_RX_IE       = 6;
    localparam int CTRL_TX_IE       = 7;

    // serial_status_reg fields
    localparam int ST_CARD_ERR = 0;
    localparam int ST_TX_END   = 2;
    localparam int ST_PARITY   = 3;
    localparam int ST_FRAMING  = 4;
    localparam int ST_OVERRUN  = 5;
    localparam int ST_RX_FULL  = 6;
    localparam int ST_TX_EMPTY = 7;

    // reset values and counter constants
    localparam logic [7:0]  MODE_RESET   = 8'h00;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  STATUS_RESET = 8'h84;
    localparam logic [15:0] ETU_RESET    = 16'h0174;
    localparam logic [15:0] CLKDIV_RESET = 16'h0002;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [3:0]  RX_LAST_BIT  = 4'h8;
    localparam logic [3:0]  TX_LAST_BIT  = 4'h9;

    // priority codes, lowest code wins
    localparam logic [1:0] IRQ_ID_RX_ERR = 2'h0;
    localparam logic [1:0] IRQ_ID_RX_FULL = 2'h1;
    localparam logic [1:0] IRQ_ID_TX_EMPTY = 2'h2;
    localparam logic [1:0] IRQ_ID_TX_END = 2'h3;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_TAIL, RX_ERR} rx_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_GUARD, TX_GAP} tx_state_e;

    typedef struct packed {
        logic receive_error_irq;
        logic receive_full_irq;
        logic transmit_empty_irq;
        logic transmit_end_irq;
    } irq_req_s;

    typedef struct packed {
        logic        din_s1;
        logic        din_s2;
        logic        din_prev;
        logic [7:0]  mode;
        logic [7:0]  ctrl;
        logic        card_mode;
        logic [15:0] etu;
        logic [15:0] clkdiv;
        logic [7:0]  status;
        logic [7:0]  seen;
        logic [7:0]  tx_data;
        logic [7:0]  rx_data;
        rx_state_e   rx_st;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_sh;
        tx_state_e   tx_st;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_sh;
        logic        tx_retry;
        logic        ck_run;
        logic        ck_ph;
        logic [15:0] ck_cnt;
        logic        wait_r;
        logic [31:0] rdata;
        irq_req_s    irq;
        logic        irq_any;
        logic [1:0]  irq_id;
        logic        xfer_rx_req;
        logic        xfer_tx_req;
        logic [7:0]  xfer_rdata;
        logic        dout;
        logic        doe;
        logic        card_clk;
    } state_s;

    localparam state_s STATE_RESET = '{
        mode: MODE_RESET,
        ctrl: CTRL_RESET,
        etu: ETU_RESET,
        clkdiv: CLKDIV_RESET,
        status: STATUS_RESET,
        rx_st: RX_IDLE,
        tx_st: TX_IDLE,
        wait_r: 1'b1,
        default: '0
    };

endpackage

// File: rtl/smartcard_serial_rx_irq_clock.sv
// Notes on behaviour
// - parity error sets flag, error request, no full
// - good parity sets full flag and request
// - errored byte still lands in receive data
// - controller read clears receive-full flag
// - no receive-full request on reception error
// - card mode error flags, error request, no full
// - timing select lets clock enables fix level
// - stopped clock finishes period, then fixed level
// - restart gives full-width first clock pulse
// - empty flag requests its interrupt, end flag outside card mode only
// - full flag and error flags request interrupts
// - controller write clears transmit-empty flag
// - priority error, full, empty, end
// - only full and empty start the controller
// - card mode: no end irq, error incl card
// - card transmit sets end and empty together
// - card error signal retransmits, end stays clear
// - card error flag never self-clears
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module smartcard_serial_rx_irq_clock (
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic [4:0]        address_in,
    input  wire logic              read_in,
    input  wire logic              write_in,
    input  wire logic [31:0]       writedata_in,
    output logic [31:0]            readdata_out,
    output logic                   waitrequest_out,
    input  wire logic              card_data_in,
    output logic                   card_data_out,
    output logic                   card_data_oe_out,
    output logic                   card_clk_out,
    input  wire logic              xfer_read_in,
    input  wire logic              xfer_write_in,
    input  wire logic [7:0]        xfer_wdata_in,
    output logic [7:0]             xfer_rdata_out,
    output logic                   xfer_rx_req_out,
    output logic                   xfer_tx_req_out,
    output card_pkg::irq_req_s     irq_req_out,
    output logic                   irq_any_out,
    output logic [1:0]             irq_id_out
);

    logic              rst_s1_r;
    logic              rst_n_r;
    card_pkg::state_s  s_r;
    card_pkg::state_s  s_nxt;
    logic [31:0]       rd_mux;
    logic              bus_go;
    logic              card;
    logic              odd;
    logic              perr;
    logic              tx_par;
    logic              idle_lvl;
    logic [15:0]       etu_m1;
    logic [15:0]       half_m1;
    logic [15:0]       ck_m1;
    logic [7:0]        clr_mask;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            s_r <= card_pkg::STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus_go   = (read_in || write_in) && !s_r.wait_r;
    assign card     = s_r.card_mode;
    assign odd      = s_r.mode[card_pkg::MODE_PAR_ODD];
    assign perr     = (^s_r.rx_sh) != odd;
    assign tx_par   = (^s_r.tx_data) ^ odd;
    // zero divisors behave as one cycle instead of wrapping to a huge count
    assign etu_m1   = (s_r.etu == '0) ? '0 : s_r.etu - card_pkg::CNT_ONE;
    assign half_m1  = {1'b0, etu_m1[15:1]};
    assign ck_m1    = (s_r.clkdiv == '0) ? '0 : s_r.clkdiv - card_pkg::CNT_ONE;
    assign idle_lvl = s_r.mode[card_pkg::MODE_TIMING_SEL]
                      && s_r.ctrl[card_pkg::CTRL_CLK_EN_HIGH];
    // clear only bits seen as 1 and written 0
    assign clr_mask = ~writedata_in[7:0] & s_r.seen;

    always_comb begin
        rd_mux = '0;
        case (address_in)
            card_pkg::ADDR_MODE: begin
                rd_mux[7:0] = s_r.mode;
            end
            card_pkg::ADDR_CTRL: begin
                rd_mux[7:0] = s_r.ctrl;
            end
            card_pkg::ADDR_STATUS: begin
                rd_mux[7:0] = s_r.status;
            end
            card_pkg::ADDR_TXDATA: begin
                rd_mux[7:0] = s_r.tx_data;
            end
            card_pkg::ADDR_RXDATA: begin
                rd_mux[7:0] = s_r.rx_data;
            end
            card_pkg::ADDR_CARD: begin
                rd_mux[0] = s_r.card_mode;
            end
            card_pkg::ADDR_ETU: begin
                rd_mux[15:0] = s_r.etu;
            end
            card_pkg::ADDR_CLKDIV: begin
                rd_mux[15:0] = s_r.clkdiv;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;

        // data pin synchroniser
        s_nxt.din_s1   = card_data_in;
        s_nxt.din_s2   = s_r.din_s1;
        s_nxt.din_prev = s_r.din_s2;

        // one wait cycle on every access keeps read data registered
        s_nxt.wait_r = 1'b1;
        if ((read_in || write_in) && s_r.wait_r) begin
            s_nxt.wait_r = 1'b0;
            s_nxt.rdata  = rd_mux;
        end
        // remember the flags handed out on the read, not ones set a cycle later
        if (read_in && s_r.wait_r && address_in == card_pkg::ADDR_STATUS) begin
            s_nxt.seen = s_r.status;
        end
        if (bus_go && write_in) begin
            case (address_in)
                card_pkg::ADDR_MODE: begin
                    s_nxt.mode = writedata_in[7:0];
                end
                card_pkg::ADDR_CTRL: begin
                    s_nxt.ctrl = writedata_in[7:0];
                end
                card_pkg::ADDR_STATUS: begin
                    // card error flag cleared only here
                    s_nxt.status = s_r.status & ~clr_mask;
                    s_nxt.seen   = s_r.seen & ~clr_mask;
                end
                card_pkg::ADDR_TXDATA: begin
                    s_nxt.tx_data = writedata_in[7:0];
                end
                card_pkg::ADDR_CARD: begin
                    s_nxt.card_mode = writedata_in[0];
                end
                card_pkg::ADDR_ETU: begin
                    s_nxt.etu = writedata_in[15:0];
                end
                card_pkg::ADDR_CLKDIV: begin
                    s_nxt.clkdiv = writedata_in[15:0];
                end
                default: begin
                end
            endcase
        end

        if (xfer_read_in && s_r.xfer_rx_req) begin
            s_nxt.status[card_pkg::ST_RX_FULL] = 1'b0;
        end
        if (xfer_write_in && s_r.xfer_tx_req) begin
            s_nxt.tx_data = xfer_wdata_in;
            s_nxt.status[card_pkg::ST_TX_EMPTY] = 1'b0;
            s_nxt.status[card_pkg::ST_TX_END] = 1'b0;
        end

        // receiver; hardware sets below override clears above
        unique case (s_r.rx_st)
            card_pkg::RX_IDLE: begin
                if (s_r.ctrl[card_pkg::CTRL_RX_EN] && s_r.din_prev && !s_r.din_s2) begin
                    s_nxt.rx_st  = card_pkg::RX_START;
                    s_nxt.rx_cnt = half_m1;
                end
            end
            card_pkg::RX_START: begin
                if (s_r.rx_cnt == '0) begin
                    // a glitch shorter than half a bit is not a start bit
                    if (!s_r.din_s2) begin
                        s_nxt.rx_st  = card_pkg::RX_BITS;
                        s_nxt.rx_cnt = etu_m1;
                        s_nxt.rx_bit = '0;
                    end else begin
                        s_nxt.rx_st = card_pkg::RX_IDLE;
                    end
                end else begin
                    s_nxt.rx_cnt = s_r.rx_cnt - card_pkg::CNT_ONE;
                end
            end
            card_pkg::RX_BITS: begin
                if (s_r.rx_cnt == '0) begin
                    s_nxt.rx_sh  = {s_r.din_s2, s_r.rx_sh[8:1]};
                    s_nxt.rx_cnt = etu_m1;
                    if (s_r.rx_bit == card_pkg::RX_LAST_BIT) begin
                        s_nxt.rx_st = card_pkg::RX_TAIL;
                    end else begin
                        s_nxt.rx_bit = s_r.rx_bit + 4'h1;
                    end
                end else begin
                    s_nxt.rx_cnt = s_r.rx_cnt - card_pkg::CNT_ONE;
                end
            end
            card_pkg::RX_TAIL: begin
                if (s_r.rx_cnt == '0) begin
                    if (s_r.status[card_pkg::ST_RX_FULL]) begin
                        s_nxt.status[card_pkg::ST_OVERRUN] = 1'b1;
                    end else begin
                        s_nxt.rx_data = s_r.rx_sh[7:0];
                        if (perr) begin
                            s_nxt.status[card_pkg::ST_PARITY] = 1'b1;
                        end else if (!card && !s_r.din_s2) begin
                            s_nxt.status[card_pkg::ST_FRAMING] = 1'b1;
                        end else begin
                            s_nxt.status[card_pkg::ST_RX_FULL] = 1'b1;
                        end
                    end
                    if (card && perr) begin
                        s_nxt.rx_st  = card_pkg::RX_ERR;
                        s_nxt.rx_cnt = etu_m1;
                    end else begin
                        s_nxt.rx_st = card_pkg::RX_IDLE;
                    end
                end else begin
                    s_nxt.rx_cnt = s_r.rx_cnt - card_pkg::CNT_ONE;
                end
            end
            card_pkg::RX_ERR: begin
                if (s_r.rx_cnt == '0) begin
                    s_nxt.rx_st = card_pkg::RX_IDLE;
                end else begin
                    s_nxt.rx_cnt = s_r.rx_cnt - card_pkg::CNT_ONE;
                end
            end
        endcase
        if (!s_r.ctrl[card_pkg::CTRL_RX_EN]) begin
            s_nxt.rx_st = card_pkg::RX_IDLE;
        end

        // transmitter
        unique case (s_r.tx_st)
            card_pkg::TX_IDLE: begin
                if (s_r.ctrl[card_pkg::CTRL_TX_EN] && !s_r.status[card_pkg::ST_TX_EMPTY]) begin
                    s_nxt.tx_sh  = {tx_par, s_r.tx_data, 1'b0};
                    s_nxt.tx_bit = '0;
                    s_nxt.tx_cnt = etu_m1;
                    s_nxt.tx_st  = card_pkg::TX_BITS;
                    // normal mode empty sets on load
                    if (!card) begin
                        s_nxt.status[card_pkg::ST_TX_EMPTY] = 1'b1;
                    end
                end
            end
            card_pkg::TX_BITS: begin
                if (s_r.tx_cnt == '0) begin
                    s_nxt.tx_cnt = etu_m1;
                    if (s_r.tx_bit == card_pkg::TX_LAST_BIT) begin
                        s_nxt.tx_st = card_pkg::TX_GUARD;
                    end else begin
                        s_nxt.tx_sh  = {1'b1, s_r.tx_sh[9:1]};
                        s_nxt.tx_bit = s_r.tx_bit + 4'h1;
                    end
                end else begin
                    s_nxt.tx_cnt = s_r.tx_cnt - card_pkg::CNT_ONE;
                end
            end
            card_pkg::TX_GUARD: begin
                if (s_r.tx_cnt == '0) begin
                    s_nxt.tx_cnt = etu_m1;
                    s_nxt.tx_st  = card_pkg::TX_GAP;
                    if (card && !s_r.din_s2) begin
                        // error signal: resend, end stays 0
                        s_nxt.status[card_pkg::ST_CARD_ERR] = 1'b1;
                        s_nxt.tx_retry = 1'b1;
                    end else begin
                        s_nxt.tx_retry = 1'b0;
                        if (card) begin
                            s_nxt.status[card_pkg::ST_TX_END]   = 1'b1;
                            s_nxt.status[card_pkg::ST_TX_EMPTY] = 1'b1;
                        end else if (s_nxt.status[card_pkg::ST_TX_EMPTY]) begin
                            s_nxt.status[card_pkg::ST_TX_END] = 1'b1;
                        end
                    end
                end else begin
                    s_nxt.tx_cnt = s_r.tx_cnt - card_pkg::CNT_ONE;
                end
            end
            card_pkg::TX_GAP: begin
                if (s_r.tx_cnt == '0) begin
                    if (s_r.tx_retry) begin
                        s_nxt.tx_sh  = {tx_par, s_r.tx_data, 1'b0};
                        s_nxt.tx_bit = '0;
                        s_nxt.tx_cnt = etu_m1;
                        s_nxt.tx_st  = card_pkg::TX_BITS;
                    end else begin
                        s_nxt.tx_st = card_pkg::TX_IDLE;
                    end
                end else begin
                    s_nxt.tx_cnt = s_r.tx_cnt - card_pkg::CNT_ONE;
                end
            end
        endcase
        if (!s_r.ctrl[card_pkg::CTRL_TX_EN]) begin
            s_nxt.tx_st    = card_pkg::TX_IDLE;
            s_nxt.tx_retry = 1'b0;
        end

        // card line is open drain in card mode: only low is driven
        s_nxt.dout = 1'b0;
        s_nxt.doe  = 1'b0;
        if (s_nxt.rx_st == card_pkg::RX_ERR) begin
            s_nxt.doe = 1'b1;
        end else if (s_nxt.tx_st == card_pkg::TX_BITS) begin
            s_nxt.dout = !card && s_nxt.tx_sh[0];
            s_nxt.doe  = !card || !s_nxt.tx_sh[0];
        end else if (!card && s_r.ctrl[card_pkg::CTRL_TX_EN]) begin
            s_nxt.dout = 1'b1;
            s_nxt.doe  = 1'b1;
        end

        // card clock: high half then low half
        if (!s_r.ck_run) begin
            if (s_r.ctrl[card_pkg::CTRL_CLK_EN_LOW]) begin
                s_nxt.ck_run = 1'b1;
                s_nxt.ck_ph  = 1'b0;
                s_nxt.ck_cnt = ck_m1;
            end
        end else if (s_r.ck_cnt == '0) begin
            s_nxt.ck_cnt = ck_m1;
            if (!s_r.ck_ph) begin
                s_nxt.ck_ph = 1'b1;
            end else if (s_r.ctrl[card_pkg::CTRL_CLK_EN_LOW]) begin
                s_nxt.ck_ph = 1'b0;
            end else begin
                s_nxt.ck_run = 1'b0;
            end
        end else begin
            s_nxt.ck_cnt = s_r.ck_cnt - card_pkg::CNT_ONE;
        end
        s_nxt.card_clk = s_nxt.ck_run ? !s_nxt.ck_ph : idle_lvl;

        // errors never raise the full request
        s_nxt.irq.receive_error_irq = s_nxt.ctrl[card_pkg::CTRL_RX_IE]
            && (s_nxt.status[card_pkg::ST_OVERRUN] || s_nxt.status[card_pkg::ST_PARITY]
                || (card ? s_nxt.status[card_pkg::ST_CARD_ERR]
                         : s_nxt.status[card_pkg::ST_FRAMING]));
        s_nxt.irq.receive_full_irq = s_nxt.ctrl[card_pkg::CTRL_RX_IE]
            && s_nxt.status[card_pkg::ST_RX_FULL];
        s_nxt.irq.transmit_empty_irq = s_nxt.ctrl[card_pkg::CTRL_TX_IE]
            && s_nxt.status[card_pkg::ST_TX_EMPTY];
        s_nxt.irq.transmit_end_irq = s_nxt.ctrl[card_pkg::CTRL_TRANSMIT_END_FLAG_IE]
            && s_nxt.status[card_pkg::ST_TX_END] && !s_nxt.card_mode;

        // controller starts on full or empty only
        s_nxt.xfer_rx_req = s_nxt.irq.receive_full_irq;
        s_nxt.xfer_tx_req = s_nxt.irq.transmit_empty_irq;
        s_nxt.xfer_rdata  = s_nxt.rx_data;

        s_nxt.irq_any = |s_nxt.irq;
        if (s_nxt.irq.receive_error_irq) begin
            s_nxt.irq_id = card_pkg::IRQ_ID_RX_ERR;
        end else if (s_nxt.irq.receive_full_irq) begin
            s_nxt.irq_id = card_pkg::IRQ_ID_RX_FULL;
        end else if (s_nxt.irq.transmit_empty_irq) begin
            s_nxt.irq_id = card_pkg::IRQ_ID_TX_EMPTY;
        end else if (s_nxt.irq.transmit_end_irq) begin
            s_nxt.irq_id = card_pkg::IRQ_ID_TX_END;
        end else begin
            s_nxt.irq_id = card_pkg::IRQ_ID_RX_ERR;
        end
    end

    assign readdata_out     = s_r.rdata;
    assign waitrequest_out  = s_r.wait_r;
    assign card_data_out    = s_r.dout;
    assign card_data_oe_out = s_r.doe;
    assign card_clk_out     = s_r.card_clk;
    assign xfer_rdata_out   = s_r.xfer_rdata;
    assign xfer_rx_req_out  = s_r.xfer_rx_req;
    assign xfer_tx_req_out  = s_r.xfer_tx_req;
    assign irq_req_out      = s_r.irq;
    assign irq_any_out      = s_r.irq_any;
    assign irq_id_out       = s_r.irq_id;

endmodule

// File: sim/card_model.sv
`timescale 1ns/1ps
module card_model #(
    parameter int BIT_NS = 80
) (
    output logic drive_out
);
    // a released line reads high through the pull-up
    initial drive_out = 1'b1;
    task automatic send(input logic [7:0] b, input logic bad);
        logic [9:0] f;
        f = {(^b) ^ bad, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            drive_out = f[i];
            #(BIT_NS);
        end
        drive_out = 1'b1;
    endtask
endmodule

// File: sim/card_props.sv
`timescale 1ns/1ps
module card_props (
    input wire logic               clock_in,
    input wire logic               rst_n_in,
    input wire logic               xfer_read_in,
    input wire logic               xfer_write_in,
    input wire logic               xfer_rx_req_out,
    input wire logic               xfer_tx_req_out,
    input wire card_pkg::irq_req_s irq_req_out,
    input wire logic               irq_any_out,
    input wire logic [1:0]         irq_id_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd_take; xfer_read_in && xfer_rx_req_out; endsequence
    sequence s_wr_take; xfer_write_in && xfer_tx_req_out; endsequence
    property p_rd_clear; s_rd_take |-> ##[1:2] !xfer_rx_req_out; endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("rx req held");
    property p_wr_clear; s_wr_take |-> ##[1:2] !xfer_tx_req_out; endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("tx req held");
    property p_rx_req; xfer_rx_req_out == irq_req_out.receive_full_irq; endproperty
    a_rx_req: assert property (p_rx_req) else $error("rx req mismatch");
    property p_tx_req; xfer_tx_req_out == irq_req_out.transmit_empty_irq; endproperty
    a_tx_req: assert property (p_tx_req) else $error("tx req mismatch");
    property p_any; irq_any_out == (|irq_req_out); endproperty
    a_any: assert property (p_any) else $error("irq any mismatch");
    property p_prio_err; irq_req_out.receive_error_irq |-> irq_id_out == 2'h0; endproperty
    a_prio_err: assert property (p_prio_err) else $error("error not first");
    property p_prio_full;
        !irq_req_out.receive_error_irq && irq_req_out.receive_full_irq |-> irq_id_out == 2'h1;
    endproperty
    a_prio_full: assert property (p_prio_full) else $error("full not second");
    property p_prio_empty;
        irq_req_out[3:1] == 3'h1 |-> irq_id_out == 2'h2;
    endproperty
    a_prio_empty: assert property (p_prio_empty) else $error("empty not third");
endmodule
bind smartcard_serial_rx_irq_clock card_props props_u (.clock_in, .rst_n_in, .xfer_read_in,
    .xfer_write_in, .xfer_rx_req_out, .xfer_tx_req_out, .irq_req_out, .irq_any_out, .irq_id_out);

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic w; logic [4:0] a; logic [15:0] v;} row_s;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic [4:0]         addr = 5'h00;
    logic               rd = 1'b0;
    logic               wr = 1'b0;
    logic               xr = 1'b0;
    logic               xw = 1'b0;
    logic [31:0]        wd = 32'h0;
    logic [31:0]        q, rdata;
    logic               waitreq, dout, doe, cclk, rxq, txq, any, drv;
    logic [7:0]         xrd;
    logic [1:0]         id;
    card_pkg::irq_req_s irq;
    int                 n_errors = 0;
    int                 n_tests = 0;
    int                 cnt;
    wire                line = drv & ~(doe & ~dout);
    row_s rows[13] = '{'{1'h0, 5'h00, 16'h0000}, '{1'h0, 5'h04, 16'h0000},
        '{1'h0, 5'h08, 16'h0084}, '{1'h0, 5'h10, 16'h0000}, '{1'h0, 5'h14, 16'h0000},
        '{1'h0, 5'h18, 16'h0174}, '{1'h0, 5'h1C, 16'h0002}, '{1'h1, 5'h18, 16'h0010},
        '{1'h1, 5'h14, 16'h0001}, '{1'h1, 5'h00, 16'h0001}, '{1'h1, 5'h04, 16'h00D0},
        '{1'h0, 5'h18, 16'h0010}, '{1'h0, 5'h04, 16'h00D0}};
    initial forever #2.5 clk = ~clk;
    card_model #(.BIT_NS(80)) card_u (.drive_out(drv));
    smartcard_serial_rx_irq_clock dut_u (.clock_in(clk), .rst_n_in(rst_n), .address_in(addr),
        .read_in(rd), .write_in(wr), .writedata_in(wd), .readdata_out(rdata),
        .waitrequest_out(waitreq), .card_data_in(line), .card_data_out(dout),
        .card_data_oe_out(doe), .card_clk_out(cclk), .xfer_read_in(xr), .xfer_write_in(xw),
        .xfer_wdata_in(8'h5A), .xfer_rdata_out(xrd), .xfer_rx_req_out(rxq),
        .xfer_tx_req_out(txq), .irq_req_out(irq), .irq_any_out(any), .irq_id_out(id));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic xp(input logic w);
        @(posedge clk);
        xw <= w;
        xr <= ~w;
        @(posedge clk);
        q = {24'h0, xrd};
        xw <= 1'b0;
        xr <= 1'b0;
    endtask
    task automatic wt(input int b);
        cnt = 0;
        while (irq[b] !== 1'b1 && cnt < 3000) begin
            @(posedge clk);
            cnt++;
        end
        repeat (3) @(posedge clk);
        if (cnt >= 3000) n_errors++;
    endtask
    task automatic summarize();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, {16'h0, rows[i].v});
            if (!rows[i].w) chk(q, {16'h0, rows[i].v});
        end
        card_u.send(8'hA5, 1'b0);
        wt(2);
        chk({26'h0, irq, id}, 32'h19);
        chk({30'h0, rxq, txq}, 32'h3);
        xp(1'b0);
        chk(q, 32'hA5);
        repeat (3) @(posedge clk);
        chk({26'h0, irq, id}, 32'h0A);
        xp(1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, any}, 32'h0);
        bus(1'b0, card_pkg::ADDR_TXDATA, 32'h0);
        chk(q, 32'h5A);
        card_u.send(8'h3C, 1'b1);
        wt(3);
        chk({30'h0, doe, dout}, 32'h2);
        chk({26'h0, irq, id}, 32'h20);
        bus(1'b0, card_pkg::ADDR_RXDATA, 32'h0);
        chk(q, 32'h3C);
        bus(1'b0, card_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h08);
        bus(1'b1, card_pkg::ADDR_STATUS, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, any}, 32'h0);
        chk({31'h0, cclk}, 32'h0);
        bus(1'b1, card_pkg::ADDR_CTRL, 32'h01);
        cnt = 0;
        while (cclk !== 1'b1 && cnt < 100) begin
            @(posedge clk);
            cnt++;
        end
        cnt = 0;
        while (cclk === 1'b1 && cnt < 100) begin
            @(posedge clk);
            cnt++;
        end
        chk(cnt, 32'h2);
        bus(1'b1, card_pkg::ADDR_CTRL, 32'h03);
        bus(1'b1, card_pkg::ADDR_CTRL, 32'h02);
        repeat (10) @(posedge clk);
        chk({31'h0, cclk}, 32'h1);
        // mid-run reset must bring back idle flags and a quiet clock
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, cclk}, 32'h0);
        bus(1'b0, card_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h84);
        summarize();
    end
endmodule
